// ### rtl/bldc_defs.vh
/*
 * Constants of the battery level detect control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 20 MHz system clock and a 32-bit classic Wishbone bus.
 */
`ifndef BLDC_DEFS_VH
`define BLDC_DEFS_VH

// Byte offsets
`define BLDC_CTRL_OFF      8'h00
`define BLDC_STAT_OFF      8'h04
`define BLDC_IRQ_STAT_OFF  8'h08
`define BLDC_IRQ_CLR_OFF   8'h0C
`define BLDC_IRQ_EN_OFF    8'h10

// Control register fields
`define BLDC_CTRL_MODE_BIT 0
`define BLDC_CTRL_SW_BIT   1

// Status register fields
`define BLDC_STAT_ON_BIT   0
`define BLDC_STAT_SET_BIT  1
`define BLDC_STAT_LOW_BIT  2
`define BLDC_STAT_HOLD_BIT 3
`define BLDC_STAT_HS_BIT   4

// Interrupt fields
`define BLDC_IRQ_SETTLED   0
`define BLDC_IRQ_OVERTIME  1
`define BLDC_IRQ_HOLD_END  2
`define BLDC_IRQ_W         3

// Reset values
`define BLDC_IRQ_RST       3'h0
`define BLDC_CTRL_RST      1'h0

// Timing
`define BLDC_CLK_KHZ       20000
`define BLDC_SETTLE_US     100
`define BLDC_HOLD_MS       600
`define BLDC_SW_MAX_MS     10
`define BLDC_SETTLE_CYC    ((`BLDC_SETTLE_US * `BLDC_CLK_KHZ + 999) / 1000)
`define BLDC_HOLD_CYC      (`BLDC_HOLD_MS * `BLDC_CLK_KHZ)
`define BLDC_SW_MAX_CYC    (`BLDC_SW_MAX_MS * `BLDC_CLK_KHZ)

`endif

// ### rtl/bldc_top.v
/*
 * Battery level detect control: heavy-load mode bit, detection sampling
 * switch, settle timing, result latch, interrupt status, Wishbone slave.
 * Assumes synchronous inputs, i_clk at 20 MHz, a classic Wishbone master,
 * and an analog comparator giving i_cmp_low while the detector is powered.
 */
// Our own choices: register access over Wishbone and the address map.
`include "bldc_defs.vh"
`default_nettype none

// Operation
// - Result counts as settled only after detector has been on 100 us.
// - High-speed clock: written mode one holds at least 0.6 s.
// - Switch and result share one bit: write drives switch, read returns result.
// - Standard parts return to normal mode with no special sequence.
module bldc_top #(
   parameter SETTLE_CYC = `BLDC_SETTLE_CYC,
   parameter HOLD_CYC   = `BLDC_HOLD_CYC,
   parameter SW_MAX_CYC = `BLDC_SW_MAX_CYC,
   parameter LOW_VOLT   = 0
) (
   input  wire        i_clk,
   input  wire        i_nrst,
   input  wire        i_high_speed_clock,
   input  wire        i_cmp_low,
   input  wire        i_wb_cyc,
   input  wire        i_wb_stb,
   input  wire        i_wb_we,
   input  wire [7:0]  i_wb_adr,
   input  wire [3:0]  i_wb_sel,
   input  wire [31:0] i_wb_dat,
   output reg  [31:0] o_wb_dat,
   output reg         o_wb_ack,
   output wire        o_detect_on,
   output wire        o_heavy_load_mode,
   output wire        o_irq
);

   function hit;
      input [7:0] adr;
      input [7:0] off;
      begin
         hit = (adr[7:2] == off[7:2]);
      end
   endfunction

   function [23:0] inc_sat;
      input [23:0] cnt;
      input [23:0] lim;
      begin
         inc_sat = (cnt == lim) ? cnt : cnt + 24'h000001;
      end
   endfunction

   reg        heavy_load_mode_bit_q;
   reg        detect_sample_switch_q;
   reg        clr_pending_q;
   reg        battery_low_result_q;
   reg        settled_q;
   reg [23:0] settle_cnt_q;
   reg [23:0] hold_cnt_q;
   reg [23:0] sw_cnt_q;
   reg [`BLDC_IRQ_W-1:0] irq_stat_q;
   reg [`BLDC_IRQ_W-1:0] irq_en_q;
   reg        heavy_load_mode_bit_d;
   reg        detect_sample_switch_d;
   reg        clr_pending_d;
   reg [23:0] hold_cnt_d;
   reg        settled_d;
   reg        battery_low_result_d;
   reg [23:0] settle_cnt_d;
   reg [23:0] sw_cnt_d;

   wire req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire wr   = req & i_wb_we & i_wb_sel[0];
   wire wr_ctrl = wr & hit(i_wb_adr, `BLDC_CTRL_OFF);
   wire wr_clr  = wr & hit(i_wb_adr, `BLDC_IRQ_CLR_OFF);
   wire wr_en   = wr & hit(i_wb_adr, `BLDC_IRQ_EN_OFF);
   wire det_on  = heavy_load_mode_bit_q | detect_sample_switch_q;
   wire hold_act = (hold_cnt_q != 24'h000000);
   wire settle_done = det_on & (settle_cnt_q == SETTLE_CYC[23:0] - 24'h000001);
   wire hold_end = (hold_cnt_q == 24'h000001);
   wire overtime = heavy_load_mode_bit_q & detect_sample_switch_q &
                   (sw_cnt_q == SW_MAX_CYC[23:0] - 24'h000001);
   wire [`BLDC_IRQ_W-1:0] ev = {hold_end, overtime, settle_done};

   assign o_detect_on       = det_on;
   assign o_heavy_load_mode = heavy_load_mode_bit_q;
   assign o_irq             = |(irq_stat_q & irq_en_q);

   // Wishbone slave, one wait state, unmapped reads return zero
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= req;
         o_wb_dat <= 32'h00000000;
         if (req && !i_wb_we) begin
            if (hit(i_wb_adr, `BLDC_CTRL_OFF)) begin
               // Shared bit reads the result, not the switch
               o_wb_dat[`BLDC_CTRL_MODE_BIT] <= heavy_load_mode_bit_q;
               o_wb_dat[`BLDC_CTRL_SW_BIT]   <= battery_low_result_q;
            end else if (hit(i_wb_adr, `BLDC_STAT_OFF)) begin
               o_wb_dat[`BLDC_STAT_ON_BIT]   <= det_on;
               o_wb_dat[`BLDC_STAT_SET_BIT]  <= settled_q;
               o_wb_dat[`BLDC_STAT_LOW_BIT]  <= battery_low_result_q;
               o_wb_dat[`BLDC_STAT_HOLD_BIT] <= hold_act;
               o_wb_dat[`BLDC_STAT_HS_BIT]   <= i_high_speed_clock;
            end else if (hit(i_wb_adr, `BLDC_IRQ_STAT_OFF)) begin
               o_wb_dat[`BLDC_IRQ_W-1:0] <= irq_stat_q;
            end else if (hit(i_wb_adr, `BLDC_IRQ_EN_OFF)) begin
               o_wb_dat[`BLDC_IRQ_W-1:0] <= irq_en_q;
            end
         end
      end
   end

   // Mode bit and sampling switch, next values
   always @* begin
      heavy_load_mode_bit_d  = heavy_load_mode_bit_q;
      detect_sample_switch_d = detect_sample_switch_q;
      clr_pending_d          = clr_pending_q;
      hold_cnt_d             = hold_cnt_q;
      if (hold_act)
         hold_cnt_d = hold_cnt_q - 24'h000001;
      if (wr_ctrl) begin
         // Shared bit write reaches only the switch, not the result
         detect_sample_switch_d = i_wb_dat[`BLDC_CTRL_SW_BIT];
         if (i_wb_dat[`BLDC_CTRL_MODE_BIT]) begin
            heavy_load_mode_bit_d = 1'b1;
            clr_pending_d         = 1'b0;
            // High-speed clock: one is held a minimum time
            if (i_high_speed_clock)
               hold_cnt_d = HOLD_CYC[23:0];
         end else if (hold_act) begin
            clr_pending_d = 1'b1;
         end else begin
            // Plain exit from protection mode
            heavy_load_mode_bit_d = 1'b0;
         end
      end else if (clr_pending_q && !hold_act) begin
         // Deferred clear once hold time is over
         heavy_load_mode_bit_d = 1'b0;
         clr_pending_d         = 1'b0;
      end
   end

   always @(posedge i_clk) begin
      if (!i_nrst) begin
         heavy_load_mode_bit_q  <= `BLDC_CTRL_RST;
         detect_sample_switch_q <= `BLDC_CTRL_RST;
         clr_pending_q          <= 1'b0;
         hold_cnt_q             <= 24'h000000;
      end else begin
         heavy_load_mode_bit_q  <= heavy_load_mode_bit_d;
         detect_sample_switch_q <= detect_sample_switch_d;
         clr_pending_q          <= clr_pending_d;
         hold_cnt_q             <= hold_cnt_d;
      end
   end

   // Settle timing and result latch, next values
   always @* begin
      settle_cnt_d         = settle_cnt_q;
      settled_d            = settled_q;
      battery_low_result_d = battery_low_result_q;
      if (!det_on) begin
         settle_cnt_d = 24'h000000;
         settled_d    = 1'b0;
      end else if (!settled_q) begin
         settle_cnt_d = inc_sat(settle_cnt_q, SETTLE_CYC[23:0]);
         // Comparator is trusted only after the settle time
         if (settle_done)
            settled_d = 1'b1;
      end
      // Result is kept after power-off so it can be read later
      if (settled_q && det_on)
         battery_low_result_d = i_cmp_low;
   end

   always @(posedge i_clk) begin
      if (!i_nrst) begin
         settle_cnt_q         <= 24'h000000;
         settled_q            <= 1'b0;
         battery_low_result_q <= 1'b0;
      end else begin
         settle_cnt_q         <= settle_cnt_d;
         settled_q            <= settled_d;
         battery_low_result_q <= battery_low_result_d;
      end
   end

   // Switch on-time watch during protection mode
   always @* begin
      sw_cnt_d = 24'h000000;
      // Counter saturates so the overtime event fires once
      if (heavy_load_mode_bit_q && detect_sample_switch_q)
         sw_cnt_d = inc_sat(sw_cnt_q, SW_MAX_CYC[23:0]);
   end

   always @(posedge i_clk) begin
      if (!i_nrst)
         sw_cnt_q <= 24'h000000;
      else
         sw_cnt_q <= sw_cnt_d;
   end

   // Sticky events; a set in the clear cycle wins
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         irq_stat_q <= `BLDC_IRQ_RST;
         irq_en_q   <= `BLDC_IRQ_RST;
      end else begin
         if (wr_en)
            irq_en_q <= i_wb_dat[`BLDC_IRQ_W-1:0];
         if (wr_clr)
            irq_stat_q <= (irq_stat_q & ~i_wb_dat[`BLDC_IRQ_W-1:0]) | ev;
         else
            irq_stat_q <= irq_stat_q | ev;
      end
   end

endmodule

`default_nettype wire

// ### tb/bldc_assertions.sv
/* Checker on the ports of bldc_top.
   Assumes one clock, sync active-low reset, bound beside the design. */
`default_nettype none
module bldc_chk #(parameter int SETTLE_CYC = 2000) (
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_high_speed_clock,
   input wire logic        i_cmp_low,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        o_detect_on,
   input wire logic        o_heavy_load_mode,
   input wire logic        o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   logic [31:0] on_cnt;
   wire logic req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   // Cycles the detector has stayed on without a break
   always @(posedge i_clk) begin
      if (!i_nrst || !o_detect_on)
         on_cnt <= 32'h0;
      else if (on_cnt != 32'hFFFFFFFF)
         on_cnt <= on_cnt + 32'h1;
   end
   AST_ACK: assert property (req |=> o_wb_ack ##1 !o_wb_ack) else $error("ack timing");
   AST_DAT0: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data off ack");
   AST_UNMAP: assert property (o_wb_ack && $past(i_wb_adr) >= 8'h14 |-> o_wb_dat == 32'h0)
      else $error("unmapped read");
   AST_SET: assert property (req && i_wb_we && i_wb_adr[7:2] == 6'h0 && i_wb_sel[0] && i_wb_dat[0]
      |=> o_heavy_load_mode) else $error("mode set");
   AST_DET: assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) >= 8'h04
      && $past(i_wb_adr) < 8'h08 && o_wb_dat[1] |-> on_cnt >= SETTLE_CYC) else $error("settled early");
   AST_HOLD: assert property ($rose(o_heavy_load_mode) && $past(i_high_speed_clock)
      |-> o_heavy_load_mode [*8]) else $error("hold short");
   AST_HS: assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) >= 8'h04
      && $past(i_wb_adr) < 8'h08 |-> o_wb_dat[4] == $past(i_high_speed_clock)) else $error("clock flag");
   AST_RST: assert property (!$past(i_nrst) |-> !o_irq && !o_heavy_load_mode && !o_wb_ack)
      else $error("reset state");
   cover property ($rose(o_heavy_load_mode));
   cover property ($rose(o_irq));
   cover property ($fell(o_detect_on));
endmodule
bind bldc_top bldc_chk #(.SETTLE_CYC(SETTLE_CYC)) bldc_chk_inst (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_high_speed_clock(i_high_speed_clock), .i_cmp_low(i_cmp_low), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_detect_on(o_detect_on),
   .o_heavy_load_mode(o_heavy_load_mode), .o_irq(o_irq));
`default_nettype wire

// ### tb/test_bldc_top.sv
/* Directed bench for bldc_top over classic Wishbone.
   Assumes short timing parameters so the run stays brief. */
`default_nettype none
module test_bldc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_nrst = 0, hs = 0, cmp = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0, rdat, v;
   logic ack, det, mode, irq;
   int bad_count = 0, total_checks = 0;
   bldc_top #(.SETTLE_CYC(8), .HOLD_CYC(80), .SW_MAX_CYC(40)) bldc_top_inst (.i_clk(i_clk),
      .i_nrst(i_nrst), .i_high_speed_clock(hs), .i_cmp_low(cmp), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .o_detect_on(det), .o_heavy_load_mode(mode), .o_irq(irq));
   initial forever #25 i_clk = ~i_clk;
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Holds the request until ack is sampled; one idle cycle follows
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      v = rdat;
      if (n >= 20) chk("ack", 0, 1);
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(0, a, 32'h0);
      chk(n, v, e);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge i_clk);
   endtask
   initial begin
      idle(4);
      i_nrst <= 1;
      rd(8'h10, 32'h0, "irq_en rst");
      bus(1, 8'h00, 32'h1);
      rd(8'h00, 32'h1, "mode next read");
      bus(1, 8'h00, 32'h0);
      chk("mode plain exit", mode, 0);
      cmp <= 1;
      bus(1, 8'h00, 32'h2);
      chk("det on", det, 1);
      rd(8'h04, 32'h1, "unsettled");
      idle(10);
      rd(8'h04, 32'h7, "settled low");
      bus(1, 8'h00, 32'h0);
      chk("det off", det, 0);
      rd(8'h00, 32'h2, "ctrl reads result");
      rd(8'h20, 32'h0, "unmapped");
      bus(1, 8'h10, 32'h1);
      chk("irq on", irq, 1);
      bus(1, 8'h10, 32'h0);
      chk("irq masked", irq, 0);
      bus(1, 8'h10, 32'h1);
      bus(1, 8'h0C, 32'h1);
      chk("irq cleared", irq, 0);
      rd(8'h08, 32'h0, "irq_stat clr");
      cmp <= 0;
      hs <= 1;
      bus(1, 8'h00, 32'h3);
      idle(44);
      rd(8'h08, 32'h3, "overtime");
      bus(1, 8'h00, 32'h0);
      rd(8'h00, 32'h1, "mode held");
      rd(8'h04, 32'h1B, "hold status");
      idle(30);
      rd(8'h08, 32'h7, "hold end");
      chk("mode after hold", mode, 0);
      hs <= 0;
      bus(1, 8'h00, 32'h1);
      bus(1, 8'h00, 32'h3);
      idle(10);
      bus(1, 8'h00, 32'h1);
      chk("pulse keeps mode", mode, 1);
      bus(1, 8'h00, 32'h0);
      chk("mode left", mode, 0);
      final_report();
   end
   initial begin
      idle(3000);
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
